// [core/trim_regs_pkg.sv]
// constants and types shared by the trim word register bank
package trim_regs_pkg;
   // serial slave address, arbitrary neutral value
   localparam logic [6:0] SLAVE_ADDR = 7'h60;
   // register indices on the serial port
   localparam logic [7:0] TRIM_LOW_OFFSET = 8'h00;
   localparam logic [7:0] TRIM_HIGH_OFFSET = 8'h01;
   // field layout
   localparam int TRIM_WIDTH = 26;
   localparam int LOW_WIDTH = 16;
   localparam int HIGH_WIDTH = 10;
   localparam int GATE_BIT = 10;
   localparam int SPARE_TOP = 15;
   localparam int SPARE_BOTTOM = 11;
   // values after reset, and the value read from an unmapped index
   localparam logic [15:0] TRIM_LOW_RESET = 16'h0000;
   localparam logic [9:0] TRIM_HIGH_RESET = 10'h000;
   localparam logic GATE_RESET = 1'b0;
   localparam logic [25:0] TRIM_APPLIED_RESET = 26'h0000000;
   localparam logic [15:0] UNMAPPED_READ = 16'h0000;
   // serial framing
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   // fastest update rate the host may use; the device accepts any rate
   localparam int MAX_UPDATE_KHZ = 38;
   typedef enum logic [3:0] {
      st_idle,
      st_addr,
      st_addr_ack,
      st_reg,
      st_reg_ack,
      st_wdata,
      st_wdata_ack,
      st_rdata,
      st_rdata_ack
   } serial_state_t;
endpackage

// [core/serial_line_events.sv]
// edge, start and stop detection on the two serial lines
`timescale 1ns/1ps
`default_nettype none
module serial_line_events (
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // serial lines, already synchronous
   input wire logic scl_in,
   input wire logic sda_in,
   // one-cycle events
   output logic scl_rise_out,
   output logic scl_fall_out,
   output logic start_out,
   output logic stop_out
);
   logic scl_prev;
   logic sda_prev;

   // idle lines sit high, so reset to high to avoid a false edge
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_prev <= scl_in;
         sda_prev <= sda_in;
      end
   end

   assign scl_rise_out = scl_in & ~scl_prev;
   assign scl_fall_out = ~scl_in & scl_prev;
   // data edge while clock stays high marks a frame boundary
   assign start_out = scl_in & scl_prev & sda_prev & ~sda_in;
   assign stop_out = scl_in & scl_prev & ~sda_prev & sda_in;
endmodule
`default_nettype wire

// [core/freq_trim_word_registers.sv]
// trim word register bank with its serial slave port
`timescale 1ns/1ps
`default_nettype none
module freq_trim_word_registers (
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // serial port
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   // output enable selection
   input wire logic sw_oe_mode_in,
   input wire logic oe_pin_in,
   // oscillator control
   output logic signed [25:0] signed_trim_word_out,
   output logic trim_update_out,
   output logic output_enable_out
);
   trim_regs_pkg::serial_state_t state;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic [3:0] bit_cnt;
   logic [7:0] shift;
   logic [7:0] tx;
   logic [7:0] reg_ptr;
   logic [7:0] rx_high;
   logic [15:0] rd_word;
   logic byte_sel;
   logic rw;
   logic master_nack;
   logic byte_done;
   logic wr_fire;
   logic [15:0] wr_word;
   logic [15:0] trim_low_half;
   logic [9:0] trim_high_half;
   logic gate;
   logic signed [25:0] trim_applied;
   logic update_pulse;
   logic load_tx;
   logic high_write;
   logic [15:0] rd_view;

   serial_line_events events (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .scl_rise_out(scl_rise),
      .scl_fall_out(scl_fall),
      .start_out(start_det),
      .stop_out(stop_det)
   );

   // read view of one register
   function automatic logic [15:0] read_word(input logic [7:0] idx,
                                             input logic [15:0] low,
                                             input logic [9:0] high,
                                             input logic gate_bit);
      logic [15:0] w;
      // unmapped indices and unused bits read as zero
      w = trim_regs_pkg::UNMAPPED_READ;
      if (idx == trim_regs_pkg::TRIM_LOW_OFFSET) begin
         w = low;
      end else if (idx == trim_regs_pkg::TRIM_HIGH_OFFSET) begin
         w = {5'h00, gate_bit, high};
      end
      return w;
   endfunction

   // a byte ends on the fall after its eighth rise, so the ack slot opens at once
   assign byte_done = scl_fall && (bit_cnt == trim_regs_pkg::BITS_PER_BYTE);
   // only the second byte of a pair commits; a lone odd byte before stop is dropped
   assign wr_fire = (state == trim_regs_pkg::st_wdata) && byte_done && byte_sel;
   assign wr_word = {rx_high, shift};
   assign high_write = wr_fire && (reg_ptr == trim_regs_pkg::TRIM_HIGH_OFFSET);
   // the fall that opens a read byte; the whole word is fetched at its high byte
   assign load_tx = scl_fall && ((state == trim_regs_pkg::st_addr_ack && rw) ||
                                 (state == trim_regs_pkg::st_rdata_ack && !master_nack));
   assign rd_view = read_word(reg_ptr, trim_low_half, trim_high_half, gate);

   // byte-level serial state machine
   // start wins over stop and every state, so a repeated start always resynchronises the state machine
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state <= trim_regs_pkg::st_idle;
         bit_cnt <= 4'h0;
         rw <= 1'b0;
      end else if (start_det) begin
         state <= trim_regs_pkg::st_addr;
         bit_cnt <= 4'h0;
      end else if (stop_det) begin
         state <= trim_regs_pkg::st_idle;
         bit_cnt <= 4'h0;
      end else begin
         case (state)
            trim_regs_pkg::st_idle: begin
               bit_cnt <= 4'h0;
            end
            trim_regs_pkg::st_addr: begin
               if (scl_rise) begin
                  bit_cnt <= bit_cnt + 4'h1;
               end
               if (byte_done) begin
                  if (shift[7:1] == trim_regs_pkg::SLAVE_ADDR) begin
                     state <= trim_regs_pkg::st_addr_ack;
                     rw <= shift[0];
                  end else begin
                     // not ours: stay quiet until the next frame
                     state <= trim_regs_pkg::st_idle;
                  end
               end
            end
            trim_regs_pkg::st_addr_ack: begin
               if (scl_fall) begin
                  bit_cnt <= 4'h0;
                  state <= rw ? trim_regs_pkg::st_rdata : trim_regs_pkg::st_reg;
               end
            end
            trim_regs_pkg::st_reg: begin
               if (scl_rise) begin
                  bit_cnt <= bit_cnt + 4'h1;
               end
               if (byte_done) begin
                  state <= trim_regs_pkg::st_reg_ack;
               end
            end
            trim_regs_pkg::st_reg_ack, trim_regs_pkg::st_wdata_ack: begin
               if (scl_fall) begin
                  bit_cnt <= 4'h0;
                  state <= trim_regs_pkg::st_wdata;
               end
            end
            trim_regs_pkg::st_wdata: begin
               if (scl_rise) begin
                  bit_cnt <= bit_cnt + 4'h1;
               end
               if (byte_done) begin
                  state <= trim_regs_pkg::st_wdata_ack;
               end
            end
            trim_regs_pkg::st_rdata: begin
               if (scl_rise) begin
                  bit_cnt <= bit_cnt + 4'h1;
               end
               if (byte_done) begin
                  state <= trim_regs_pkg::st_rdata_ack;
               end
            end
            trim_regs_pkg::st_rdata_ack: begin
               if (scl_fall) begin
                  bit_cnt <= 4'h0;
                  // a master nack ends the read; wait for stop or restart
                  state <= master_nack ? trim_regs_pkg::st_idle : trim_regs_pkg::st_rdata;
               end
            end
            default: begin
               state <= trim_regs_pkg::st_idle;
            end
         endcase
      end
   end

   // receive shifter, sampled on the rising clock edge, msb first
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         shift <= 8'h00;
      end else if (scl_rise) begin
         shift <= {shift[6:0], sda_in};
      end
   end

   // master acknowledge during reads
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         master_nack <= 1'b0;
      end else if (state == trim_regs_pkg::st_rdata_ack && scl_rise) begin
         master_nack <= sda_in;
      end
   end

   // register pointer and byte pairing, high byte of each word first
   // pointer survives a stop so a read can follow a separate index write
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         reg_ptr <= 8'h00;
         byte_sel <= 1'b0;
         rx_high <= 8'h00;
      end else if (state == trim_regs_pkg::st_reg && byte_done) begin
         reg_ptr <= shift;
         byte_sel <= 1'b0;
      end else if (state == trim_regs_pkg::st_wdata && byte_done) begin
         if (!byte_sel) begin
            rx_high <= shift;
            byte_sel <= 1'b1;
         end else begin
            byte_sel <= 1'b0;
            reg_ptr <= reg_ptr + 8'h01;
         end
      end else if (load_tx) begin
         byte_sel <= ~byte_sel;
         if (byte_sel) begin
            reg_ptr <= reg_ptr + 8'h01;
         end
      end
   end

   // transmit shifter; word is snapshot at its high byte so halves agree
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         tx <= 8'h00;
         rd_word <= 16'h0000;
      end else if (load_tx) begin
         if (!byte_sel) begin
            rd_word <= rd_view;
            tx <= rd_view[15:8];
         end else begin
            tx <= rd_word[7:0];
         end
      end else if (state == trim_regs_pkg::st_rdata && scl_fall) begin
         tx <= {tx[6:0], 1'b0};
      end
   end

   // trim halves and the output gate bit
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         trim_low_half <= trim_regs_pkg::TRIM_LOW_RESET;
         trim_high_half <= trim_regs_pkg::TRIM_HIGH_RESET;
         gate <= trim_regs_pkg::GATE_RESET;
      end else if (wr_fire) begin
         if (reg_ptr == trim_regs_pkg::TRIM_LOW_OFFSET) begin
            // a low word write stays parked here until the high word arrives
            trim_low_half <= wr_word;
         end else if (reg_ptr == trim_regs_pkg::TRIM_HIGH_OFFSET) begin
            // bits 15:11 are simply not stored
            trim_high_half <= wr_word[9:0];
            if (sw_oe_mode_in) begin
               gate <= wr_word[trim_regs_pkg::GATE_BIT];
            end
         end
      end
   end

   // applied word moves only on a high word load, pairing with the stored low word
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         trim_applied <= trim_regs_pkg::TRIM_APPLIED_RESET;
         update_pulse <= 1'b0;
      end else if (high_write) begin
         // relies on the host loading the low word beforehand
         trim_applied <= {wr_word[9:0], trim_low_half};
         update_pulse <= 1'b1;
      end else begin
         update_pulse <= 1'b0;
      end
   end

   // the update pulse marks the edge on which the synthesis loop should retune
   // signed value passes straight to the synthesis loop
   assign signed_trim_word_out = trim_applied;
   assign trim_update_out = update_pulse;
   // pin control bypasses the gate bit entirely
   assign output_enable_out = sw_oe_mode_in ? gate : oe_pin_in;

   // open-drain: only ever pull low
   // no clock stretching; each scl level must last two clocks or more to be seen
   // every byte of a write to this address is acked, even for an unmapped index, whose data is then discarded
   assign sda_out = 1'b0;
   always_comb begin
      case (state)
         trim_regs_pkg::st_addr_ack,
         trim_regs_pkg::st_reg_ack,
         trim_regs_pkg::st_wdata_ack: begin
            sda_oe_out = 1'b1;
         end
         trim_regs_pkg::st_rdata: begin
            sda_oe_out = ~tx[7];
         end
         default: begin
            sda_oe_out = 1'b0;
         end
      endcase
   end
endmodule
`default_nettype wire

// [test/trim_regs_assertions.sv]
// port checker for the trim word register bank
`timescale 1ns/1ps
`default_nettype none
module trim_regs_assertions (
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // serial port
   input wire logic scl_in,
   input wire logic sda_oe_out,
   // output enable
   input wire logic sw_oe_mode_in,
   input wire logic oe_pin_in,
   // oscillator control
   input wire logic signed [25:0] signed_trim_word_out,
   input wire logic trim_update_out,
   input wire logic output_enable_out
);
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (reset_in);
   a_reset_trim_zero:
      assert property ($fell(reset_in) |-> signed_trim_word_out == 26'h0000000)
      else $error("trim not cleared");
   a_reset_gate_off:
      assert property ($fell(reset_in) && sw_oe_mode_in |-> !output_enable_out)
      else $error("gate not off after reset");
   a_trim_moves_on_update:
      assert property ($changed(signed_trim_word_out) |-> trim_update_out)
      else $error("trim moved without update");
   a_update_one_cycle:
      assert property (trim_update_out |=> !trim_update_out)
      else $error("update pulse too long");
   a_update_scl_low:
      assert property (trim_update_out |-> !scl_in)
      else $error("update outside byte end");
   a_pin_mode_oe:
      assert property (!sw_oe_mode_in |-> output_enable_out == oe_pin_in)
      else $error("pin control ignored");
   a_gate_on_commit:
      assert property (sw_oe_mode_in && $stable(sw_oe_mode_in) && $changed(output_enable_out)
         |-> trim_update_out)
      else $error("gate moved without commit");
   a_sda_quiet_scl_high:
      assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_out))
      else $error("data moved while clock high");
   c_update: cover property (trim_update_out);
   c_ack: cover property ($rose(sda_oe_out));
   c_pin_mode: cover property (!sw_oe_mode_in && oe_pin_in);
endmodule
bind freq_trim_word_registers trim_regs_assertions trim_regs_assertions_i (.*);
`default_nettype wire

// [test/serial_host_model.sv]
// serial bus host model driving the trim register bank
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
   // clock
   input wire logic clk_in,
   // serial lines, released data is pulled high
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_low_out
);
   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   // data only moves while the clock is low
   task automatic bit_io(input logic b, output logic r);
      scl_out <= 1'b0;
      tick(2);
      sda_low_out <= !b;
      tick(2);
      scl_out <= 1'b1;
      tick(2);
      r = sda_in;
      tick(2);
   endtask
   task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
      output logic r);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(last, r);
   endtask
   // start or stop, clock left high so the bus stands still afterwards
   task automatic frame_edge(input logic stop);
      scl_out <= 1'b0;
      tick(2);
      sda_low_out <= stop;
      tick(2);
      scl_out <= 1'b1;
      tick(4);
      sda_low_out <= !stop;
      tick(4);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] idx, input logic [31:0] d,
      input int n, output logic ok);
      logic [7:0] q;
      logic r;
      frame_edge(1'b0);
      xfer({a, 1'b0}, 1'b1, q, r);
      ok = !r;
      xfer(idx, 1'b1, q, r);
      ok &= !r;
      for (int k = 0; k < 2 * n; k++) begin
         xfer(d[16 * (k / 2) + 8 * (1 - k % 2) +: 8], 1'b1, q, r);
         ok &= !r;
      end
      frame_edge(1'b1);
      tick(3290);
   endtask
   task automatic rd(input logic [7:0] idx, output logic [15:0] w);
      logic [7:0] q;
      logic r;
      frame_edge(1'b0);
      xfer({trim_regs_pkg::SLAVE_ADDR, 1'b0}, 1'b1, q, r);
      xfer(idx, 1'b1, q, r);
      frame_edge(1'b0);
      xfer({trim_regs_pkg::SLAVE_ADDR, 1'b1}, 1'b1, q, r);
      xfer(8'hFF, 1'b0, w[15:8], r);
      xfer(8'hFF, 1'b1, w[7:0], r);
      frame_edge(1'b1);
   endtask
endmodule
`default_nettype wire

// [test/tb.sv]
// testbench for the trim word register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk_in, reset_in, sw_oe_mode_in, oe_pin_in, scl, host_low, sda_oe_out, sda_out;
   logic trim_update_out, output_enable_out, ok;
   logic signed [25:0] signed_trim_word_out;
   logic [31:0] seed = 32'h000039FB;
   logic [31:0] tbl [3] = '{32'h00E6_6666, 32'h0780_0000, 32'hF9FF_FFFF};
   logic [15:0] w;
   int errors = 0, compares = 0, pulses = 0, lo = 0, hi = 0, gate = 0, app = 0, n_upd = 0;
   wire logic sda = ~(host_low | (sda_oe_out & !sda_out));
   freq_trim_word_registers freq_trim_word_registers_i (.clk_in(clk_in), .reset_in(reset_in),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
      .sw_oe_mode_in(sw_oe_mode_in), .oe_pin_in(oe_pin_in),
      .signed_trim_word_out(signed_trim_word_out), .trim_update_out(trim_update_out),
      .output_enable_out(output_enable_out));
   serial_host_model serial_host_model_i (.clk_in(clk_in), .sda_in(sda), .scl_out(scl),
      .sda_low_out(host_low));
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      if (trim_update_out === 1'b1) begin
         pulses <= pulses + 1;
      end
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input string what, input int exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic results();
      if (errors == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic verify();
      serial_host_model_i.rd(trim_regs_pkg::TRIM_LOW_OFFSET, w);
      check("low", lo, 32'(w));
      serial_host_model_i.rd(trim_regs_pkg::TRIM_HIGH_OFFSET, w);
      check("high", gate << 10 | hi, 32'(w));
      check("trim", app, 32'(signed_trim_word_out));
      check("updates", n_upd, 32'(pulses));
      check("oe", sw_oe_mode_in ? gate : int'(oe_pin_in), 32'(output_enable_out));
   endtask
   // model copy of a write; the high word applies the stored low word
   task automatic put(input int idx, input int n, input logic [31:0] d);
      serial_host_model_i.wr(trim_regs_pkg::SLAVE_ADDR, 8'(idx), d, n, ok);
      check("ack", 1, 32'(ok));
      for (int k = 0; k < n; k++) begin
         w = d[16 * k +: 16];
         if (idx + k == 0) begin
            lo = int'(w);
         end
         if (idx + k == 1) begin
            hi = int'(w[9:0]);
            gate = sw_oe_mode_in ? int'(w[10]) : gate;
            app = (hi << 22 | lo << 6) >>> 6;
            n_upd++;
         end
      end
   endtask
   task automatic restart();
      repeat (3) @(posedge clk_in);
      reset_in <= 1'b0;
      lo = 0;
      hi = 0;
      gate = 0;
      app = 0;
      @(posedge clk_in);
      verify();
   endtask
   initial begin
      repeat (90000) @(posedge clk_in);
      errors++;
      results();
   end
   initial begin
      reset_in = 1'b1;
      sw_oe_mode_in = 1'b1;
      oe_pin_in = 1'b0;
      restart();
      for (int i = 0; i < 5; i++) begin
         put(0, 1, rnd());
         verify();
         put(1, 1, rnd());
         verify();
         sw_oe_mode_in <= i[0];
         oe_pin_in <= seed[9];
      end
      sw_oe_mode_in <= 1'b1;
      foreach (tbl[i]) begin
         put(0, 2, tbl[i]);
         verify();
      end
      put(5, 1, rnd());
      serial_host_model_i.rd(8'h05, w);
      check("unmapped", int'(trim_regs_pkg::UNMAPPED_READ), 32'(w));
      serial_host_model_i.wr(trim_regs_pkg::SLAVE_ADDR ^ 7'h01, 8'h01, rnd(), 1, ok);
      check("nack", 0, 32'(ok));
      verify();
      reset_in <= 1'b1;
      restart();
      results();
   end
endmodule
`default_nettype wire
